// file: logic/csbd_core.sv
`timescale 1ns/1ps
`include "csbd_defines.svh"

module csbd_core (
	input  wire logic                 sys_clk,
	input  wire logic                 rstn,
	input  wire csbd_pkg::csbd_inst_e inst_class,
	input  wire logic                 dm_rd,
	input  wire logic                 dm_wr,
	input  wire logic [6:0]           dm_addr,
	input  wire logic [7:0]           dm_wdata,
	output logic      [7:0]           dm_rdata,
	output logic                      dm_rvalid,
	output logic                      fpage_wr_stb,
	output logic                      fpage_rd_stb,
	output logic                      spage_wr_stb,
	output logic                      spage_rd_stb,
	output logic      [4:0]           fs_addr,
	output logic      [7:0]           fs_wdata,
	input  wire logic [7:0]           fs_rdata,
	input  wire logic                 pc_step,
	input  wire logic                 short_jump_instruction,
	input  wire logic                 short_call_instruction,
	input  wire logic                 long_jump_instruction,
	input  wire logic                 long_call_instruction,
	input  wire logic [10:0]          inst_target,
	output logic      [10:0]          pc_out,
	output logic                      push_stb,
	output logic      [10:0]          push_addr,
	input  wire logic                 alu_carry_we,
	input  wire logic                 alu_carry,
	input  wire logic                 alu_half_carry_we,
	input  wire logic                 alu_half_carry,
	input  wire logic                 alu_zero_we,
	input  wire logic                 alu_zero,
	input  wire logic                 clear_watchdog_instruction,
	input  wire logic                 sleep_instruction,
	input  wire logic                 watchdog_timeout,
	input  wire logic                 instruction_clock,
	input  wire logic                 timer0_mode_setting,
	input  wire logic                 cfg_timer0_low_osc,
	input  wire logic                 timer0_external_clock_pin,
	input  wire logic                 low_osc_clk_in,
	input  wire logic [7:0]           port_a_pin_in,
	input  wire logic [7:0]           port_a_dir_out,
	input  wire logic                 port_read_option,
	output logic      [7:0]           port_a_out
);

	import csbd_pkg::*;

	// ======================================================
	// registers
	logic [10:0] pc_reg,        pc_next;
	logic [2:0]  pc_high_reg;
	logic        push_stb_reg;
	logic [10:0] push_addr_reg;
	logic        carry_reg,     half_carry_reg, zero_reg;
	logic        power_down_flag_reg, time_out_flag_reg;
	logic        spare_status_bit_reg;
	logic [1:0]  bank_select_reg;
	logic [7:0]  pointer_reg;
	logic [7:0]  timer0_reg,    timer0_next;
	logic [7:0]  port_a_reg;
	logic [7:0]  pin_s1_reg,    pin_s2_reg;
	logic [2:0]  ext_sync_reg,  lf_sync_reg;
	logic        rd1_reg;
	csbd_src_e   src1_reg;
	logic [7:0]  sfr_rd_reg;
	logic [7:0]  dm_rdata_reg;
	logic        dm_rvalid_reg;
	logic        f_wr_reg,      f_rd_reg, s_wr_reg, s_rd_reg;
	logic [4:0]  fs_addr_reg;
	logic [7:0]  fs_wdata_reg;

	// ======================================================
	// address decode
	wire        gen_acc   = (inst_class == CSBD_INST_GENERAL);
	wire        ind_acc   = (dm_addr == `CSBD_ADDR_INDIRECT);
	wire [6:0]  loc       = ind_acc ? pointer_reg[6:0] : dm_addr;
	wire        is_sfr    = (loc < `CSBD_GPR_LO);
	wire        gen_wr    = gen_acc & dm_wr;
	wire        gen_rd    = gen_acc & dm_rd;
	wire        sfr_wr    = gen_wr & is_sfr;
	wire        wr_timer0 = sfr_wr & (loc == `CSBD_ADDR_TIMER0);
	wire        wr_pc_low = sfr_wr & (loc == `CSBD_ADDR_PC_LOW);
	wire        wr_status = sfr_wr & (loc == `CSBD_ADDR_STATUS);
	wire        wr_ptr    = sfr_wr & (loc == `CSBD_ADDR_POINTER);
	wire        wr_port_a = sfr_wr & (loc == `CSBD_ADDR_PORT_A);
	wire        wr_pc_hi  = sfr_wr & (loc == `CSBD_ADDR_PC_HIGH);

	// banks 2 and 3 fold onto 0 and 1 below 0x40; above it all fold onto 0
	wire        gpr_in_b1 = bank_select_reg[0] & (loc < `CSBD_GPR_B1_END);
	wire [6:0]  gpr_addr  = gpr_in_b1 ? (`CSBD_GPR_B1_BASE | {2'h0, loc[4:0]})
	                                  : (loc - `CSBD_GPR_LO);
	wire        gpr_wr    = gen_wr & ~is_sfr;

	// f/s pages use the raw five-bit address, bank bits play no part
	wire        f_wr      = (inst_class == CSBD_INST_F_WRITE) & dm_wr;
	wire        f_rd      = (inst_class == CSBD_INST_F_READ)  & dm_rd;
	wire        s_wr      = (inst_class == CSBD_INST_S_WRITE) & dm_wr;
	wire        s_rd      = (inst_class == CSBD_INST_S_READ)  & dm_rd;
	wire        fs_acc    = f_wr | f_rd | s_wr | s_rd;
	wire [4:0]  fs_loc    = dm_addr[4:0];

	// ======================================================
	// read multiplexing
	wire [7:0]  status_rd = {bank_select_reg, spare_status_bit_reg, time_out_flag_reg,
	                         power_down_flag_reg, zero_reg, half_carry_reg, carry_reg};
	wire [7:0]  port_a_rd = (port_a_dir_out & {8{port_read_option}} & port_a_reg)
	                      | (~(port_a_dir_out & {8{port_read_option}}) & pin_s2_reg);
	wire [7:0]  sfr_rd    = (loc == `CSBD_ADDR_TIMER0)  ? timer0_reg :
	                        (loc == `CSBD_ADDR_PC_LOW)  ? pc_reg[7:0] :
	                        (loc == `CSBD_ADDR_STATUS)  ? status_rd :
	                        (loc == `CSBD_ADDR_POINTER) ? pointer_reg :
	                        (loc == `CSBD_ADDR_PORT_A)  ? port_a_rd :
	                        `CSBD_BYTE_ZERO;
	wire [7:0]  gpr_rdata;
	wire [7:0]  final_rd  = (src1_reg == CSBD_SRC_GPR) ? gpr_rdata :
	                        (src1_reg == CSBD_SRC_FS)  ? fs_rdata  : sfr_rd_reg;

	// ======================================================
	// general purpose ram
	csbd_gpr_mem #(
		.AW    (`CSBD_GPR_AW),
		.WORDS (`CSBD_GPR_WORDS)
	) u_gpr (
		.sys_clk (sys_clk),
		.wr_en   (gpr_wr),
		.addr    (gpr_addr),
		.wdata   (dm_wdata),
		.rdata   (gpr_rdata)
	);

	// ======================================================
	// program counter
	wire [10:0] pc_inc = pc_reg + `CSBD_PC_ONE;
	wire        is_call = short_call_instruction | long_call_instruction;

	always_comb begin
		pc_next = pc_reg;
		if (long_jump_instruction | long_call_instruction) begin
			pc_next = inst_target;
		end else if (short_call_instruction) begin
			pc_next = {pc_high_reg, inst_target[7:0]};
		end else if (short_jump_instruction) begin
			pc_next = {pc_high_reg[2:1], inst_target[8:0]};
		end else if (wr_pc_low) begin
			pc_next = {pc_high_reg, dm_wdata};
		end else if (pc_step) begin
			pc_next = pc_inc;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pc_reg        <= `CSBD_PC_RST;
			pc_high_reg   <= `CSBD_PC_HIGH_RST;
			push_stb_reg  <= 1'b0;
			push_addr_reg <= `CSBD_PC_RST;
		end else begin
			pc_reg       <= pc_next;
			push_stb_reg <= is_call;
			if (is_call) begin
				push_addr_reg <= pc_inc;
			end
			if (wr_pc_hi) begin
				pc_high_reg <= dm_wdata[2:0];
			end
		end
	end

	// ======================================================
	// core status
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			carry_reg            <= 1'b0;
			half_carry_reg       <= 1'b0;
			zero_reg             <= 1'b0;
			power_down_flag_reg  <= 1'b1;
			time_out_flag_reg    <= 1'b1;
			spare_status_bit_reg <= 1'b0;
			bank_select_reg      <= `CSBD_BANK_RST;
		end else begin
			// flag updates from the instruction override a software write
			if (alu_carry_we) begin
				carry_reg <= alu_carry;
			end else if (wr_status) begin
				carry_reg <= dm_wdata[`CSBD_ST_CARRY];
			end
			if (alu_half_carry_we) begin
				half_carry_reg <= alu_half_carry;
			end else if (wr_status) begin
				half_carry_reg <= dm_wdata[`CSBD_ST_HALF_CARRY];
			end
			if (alu_zero_we) begin
				zero_reg <= alu_zero;
			end else if (wr_status) begin
				zero_reg <= dm_wdata[`CSBD_ST_ZERO];
			end
			if (clear_watchdog_instruction) begin
				power_down_flag_reg <= 1'b1;
			end else if (sleep_instruction) begin
				power_down_flag_reg <= 1'b0;
			end else if (wr_status) begin
				power_down_flag_reg <= dm_wdata[`CSBD_ST_POWER_DOWN];
			end
			// a timeout is never lost to a simultaneous set
			if (watchdog_timeout) begin
				time_out_flag_reg <= 1'b0;
			end else if (clear_watchdog_instruction | sleep_instruction) begin
				time_out_flag_reg <= 1'b1;
			end else if (wr_status) begin
				time_out_flag_reg <= dm_wdata[`CSBD_ST_TIME_OUT];
			end
			if (wr_status) begin
				spare_status_bit_reg <= dm_wdata[`CSBD_ST_SPARE];
				bank_select_reg      <= dm_wdata[`CSBD_ST_BANK_HI:`CSBD_ST_BANK_LO];
			end
		end
	end

	// ======================================================
	// pointer and port A
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pointer_reg <= `CSBD_POINTER_RST;
			port_a_reg  <= `CSBD_BYTE_ZERO;
			pin_s1_reg  <= `CSBD_BYTE_ZERO;
			pin_s2_reg  <= `CSBD_BYTE_ZERO;
		end else begin
			pin_s1_reg <= port_a_pin_in;
			pin_s2_reg <= pin_s1_reg;
			if (wr_ptr) begin
				pointer_reg <= dm_wdata;
			end
			if (wr_port_a) begin
				port_a_reg <= dm_wdata;
			end
		end
	end

	// ======================================================
	// timer0 count window
	wire ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
	wire lf_rise  = lf_sync_reg[1] & ~lf_sync_reg[2];
	wire t0_tick  = !timer0_mode_setting ? instruction_clock :
	                cfg_timer0_low_osc   ? lf_rise : ext_rise;

	always_comb begin
		timer0_next = timer0_reg;
		if (wr_timer0) begin
			timer0_next = dm_wdata;
		end else if (t0_tick) begin
			timer0_next = timer0_reg + 8'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			timer0_reg   <= `CSBD_BYTE_ZERO;
			ext_sync_reg <= 3'h0;
			lf_sync_reg  <= 3'h0;
		end else begin
			timer0_reg   <= timer0_next;
			ext_sync_reg <= {ext_sync_reg[1:0], timer0_external_clock_pin};
			lf_sync_reg  <= {lf_sync_reg[1:0], low_osc_clk_in};
		end
	end

	// ======================================================
	// f/s page strobes and read return pipeline
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			f_wr_reg      <= 1'b0;
			f_rd_reg      <= 1'b0;
			s_wr_reg      <= 1'b0;
			s_rd_reg      <= 1'b0;
			fs_addr_reg   <= `CSBD_FS_ADDR_RST;
			fs_wdata_reg  <= `CSBD_BYTE_ZERO;
			rd1_reg       <= 1'b0;
			src1_reg      <= CSBD_SRC_SFR;
			sfr_rd_reg    <= `CSBD_BYTE_ZERO;
			dm_rdata_reg  <= `CSBD_BYTE_ZERO;
			dm_rvalid_reg <= 1'b0;
		end else begin
			f_wr_reg <= f_wr;
			f_rd_reg <= f_rd;
			s_wr_reg <= s_wr;
			s_rd_reg <= s_rd;
			if (fs_acc) begin
				fs_addr_reg  <= fs_loc;
				fs_wdata_reg <= dm_wdata;
			end
			rd1_reg <= gen_rd | f_rd | s_rd;
			if (f_rd | s_rd) begin
				src1_reg <= CSBD_SRC_FS;
			end else if (gen_rd & ~is_sfr) begin
				src1_reg <= CSBD_SRC_GPR;
			end else begin
				src1_reg <= CSBD_SRC_SFR;
			end
			sfr_rd_reg    <= sfr_rd;
			dm_rvalid_reg <= rd1_reg;
			if (rd1_reg) begin
				dm_rdata_reg <= final_rd;
			end
		end
	end

	// ======================================================
	// outputs
	assign dm_rdata     = dm_rdata_reg;
	assign dm_rvalid    = dm_rvalid_reg;
	assign fpage_wr_stb = f_wr_reg;
	assign fpage_rd_stb = f_rd_reg;
	assign spage_wr_stb = s_wr_reg;
	assign spage_rd_stb = s_rd_reg;
	assign fs_addr      = fs_addr_reg;
	assign fs_wdata     = fs_wdata_reg;
	assign pc_out       = pc_reg;
	assign push_stb     = push_stb_reg;
	assign push_addr    = push_addr_reg;
	assign port_a_out   = port_a_reg;

endmodule : csbd_core

// file: logic/csbd_defines.svh
`ifndef CSBD_DEFINES_SVH
`define CSBD_DEFINES_SVH

// ==========================================================
// r-page register locations
`define CSBD_ADDR_INDIRECT   7'h00
`define CSBD_ADDR_TIMER0     7'h01
`define CSBD_ADDR_PC_LOW     7'h02
`define CSBD_ADDR_STATUS     7'h03
`define CSBD_ADDR_POINTER    7'h04
`define CSBD_ADDR_PORT_A     7'h05
`define CSBD_ADDR_PC_HIGH    7'h0A

// ==========================================================
// data memory map
`define CSBD_GPR_LO          7'h20
`define CSBD_GPR_B1_END      7'h40
`define CSBD_GPR_B1_BASE     7'h60
`define CSBD_GPR_WORDS       128
`define CSBD_GPR_AW          7

// ==========================================================
// core status field positions
`define CSBD_ST_CARRY        0
`define CSBD_ST_HALF_CARRY   1
`define CSBD_ST_ZERO         2
`define CSBD_ST_POWER_DOWN   3
`define CSBD_ST_TIME_OUT     4
`define CSBD_ST_SPARE        5
`define CSBD_ST_BANK_LO      6
`define CSBD_ST_BANK_HI      7

// ==========================================================
// reset values
`define CSBD_PC_RST          11'h000
`define CSBD_PC_LOW_RST      8'h00
`define CSBD_BANK_RST        2'h0
`define CSBD_POINTER_RST     8'h00
`define CSBD_PC_HIGH_RST     3'h0
`define CSBD_BYTE_ZERO       8'h00
`define CSBD_PC_ONE          11'h001
`define CSBD_FS_ADDR_RST     5'h00

`endif

// file: logic/csbd_gpr_mem.sv
`timescale 1ns/1ps

module csbd_gpr_mem #(
	parameter int AW    = 7,
	parameter int WORDS = 128
) (
	input  wire logic          sys_clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic      [7:0]    rdata
);

	// ======================================================
	// storage, no reset: contents are undefined after power-up
	logic [7:0] mem_reg [WORDS];
	logic [7:0] rdata_reg;

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem_reg[addr] <= wdata;
		end
		rdata_reg <= mem_reg[addr];
	end

	assign rdata = rdata_reg;

endmodule : csbd_gpr_mem

// file: logic/csbd_pkg.sv
package csbd_pkg;

	// ======================================================
	// instruction class presented with each data access
	typedef enum logic [4:0] {
		CSBD_INST_GENERAL = 5'h01,
		CSBD_INST_F_WRITE = 5'h02,
		CSBD_INST_F_READ  = 5'h04,
		CSBD_INST_S_WRITE = 5'h08,
		CSBD_INST_S_READ  = 5'h10
	} csbd_inst_e;

	// ======================================================
	// source of read data in the return pipeline
	typedef enum logic [2:0] {
		CSBD_SRC_SFR = 3'h1,
		CSBD_SRC_GPR = 3'h2,
		CSBD_SRC_FS  = 3'h4
	} csbd_src_e;

endpackage : csbd_pkg

// file: tb/csbd_core_props.sv
`timescale 1ns/1ps

module csbd_core_props (
	input wire logic                 sys_clk,
	input wire logic                 rstn,
	input wire csbd_pkg::csbd_inst_e inst_class,
	input wire logic                 dm_rd,
	input wire logic                 dm_wr,
	input wire logic [6:0]           dm_addr,
	input wire logic [7:0]           dm_rdata,
	input wire logic                 dm_rvalid,
	input wire logic                 fpage_wr_stb,
	input wire logic                 fpage_rd_stb,
	input wire logic                 spage_wr_stb,
	input wire logic                 spage_rd_stb,
	input wire logic [4:0]           fs_addr,
	input wire logic [7:0]           fs_rdata,
	input wire logic                 pc_step,
	input wire logic                 short_jump_instruction,
	input wire logic                 short_call_instruction,
	input wire logic                 long_jump_instruction,
	input wire logic                 long_call_instruction,
	input wire logic [10:0]          inst_target,
	input wire logic [10:0]          pc_out,
	input wire logic                 push_stb,
	input wire logic [10:0]          push_addr
);
	import csbd_pkg::*;
	// ==========================================================
	// helpers
	wire long_any = long_jump_instruction || long_call_instruction;
	wire any_jmp  = long_any || short_call_instruction || short_jump_instruction;
	wire any_stb  = fpage_wr_stb || fpage_rd_stb || spage_wr_stb || spage_rd_stb;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_fread;
		dm_rd && inst_class == CSBD_INST_F_READ ##1 fpage_rd_stb;
	endsequence
	// ==========================================================
	// assertions
	a_fread_return: assert property (s_fread |=> dm_rvalid && dm_rdata == $past(fs_rdata))
		else $error("f-page read data not returned");
	a_read_latency: assert property (dm_rd |-> ##2 dm_rvalid)
		else $error("read return not two cycles after request");
	a_fs_write: assert property (dm_wr && inst_class == CSBD_INST_F_WRITE
		|=> fpage_wr_stb && !spage_wr_stb && fs_addr == $past(dm_addr[4:0]))
		else $error("f-page write strobe or address wrong");
	a_general_quiet: assert property ((dm_rd || dm_wr) && inst_class == CSBD_INST_GENERAL
		|=> !any_stb)
		else $error("general access raised a page strobe");
	a_long_load: assert property (long_any |=> pc_out == $past(inst_target))
		else $error("long transfer did not load all counter bits");
	a_call_push: assert property (long_call_instruction
		|=> push_stb && push_addr == $past(pc_out) + 11'h001)
		else $error("long call push wrong");
	a_short_call: assert property (short_call_instruction && !long_any
		|=> push_stb && pc_out[7:0] == $past(inst_target[7:0]))
		else $error("short call load or push wrong");
	a_short_jump: assert property (short_jump_instruction && !long_any
		&& !short_call_instruction |=> !push_stb && pc_out[8:0] == $past(inst_target[8:0]))
		else $error("short jump load wrong");
	a_pc_step: assert property (pc_step && !any_jmp && !dm_wr
		|=> pc_out == $past(pc_out) + 11'h001)
		else $error("counter did not advance by one");
endmodule : csbd_core_props

bind csbd_core csbd_core_props chk_u (.sys_clk, .rstn, .inst_class, .dm_rd, .dm_wr,
	.dm_addr, .dm_rdata, .dm_rvalid, .fpage_wr_stb, .fpage_rd_stb, .spage_wr_stb,
	.spage_rd_stb, .fs_addr, .fs_rdata, .pc_step, .short_jump_instruction,
	.short_call_instruction, .long_jump_instruction, .long_call_instruction,
	.inst_target, .pc_out, .push_stb, .push_addr);

// file: tb/csbd_fs_model.sv
`timescale 1ns/1ps

module csbd_fs_model (
	input  wire logic       sys_clk,
	input  wire logic       fpage_wr_stb,
	input  wire logic       fpage_rd_stb,
	input  wire logic       spage_wr_stb,
	input  wire logic       spage_rd_stb,
	input  wire logic [4:0] fs_addr,
	input  wire logic [7:0] fs_wdata,
	output logic      [7:0] fs_rdata
);
	// ==========================================================
	// separate page stores, so a crossed strobe returns wrong data
	logic [7:0] fmem [32];
	logic [7:0] smem [32];
	logic       tog = 1'h0;
	always_ff @(posedge sys_clk) begin
		tog <= ~tog;
		if (fpage_wr_stb) fmem[fs_addr] <= fs_wdata;
		if (spage_wr_stb) smem[fs_addr] <= fs_wdata;
	end
	// outside a read the bus toggles, so stale data cannot pass
	assign fs_rdata = fpage_rd_stb ? fmem[fs_addr] : spage_rd_stb ? smem[fs_addr] : {8{tog}};
endmodule : csbd_fs_model

// file: tb/test_core_sfr_bank_decoder.sv
`timescale 1ns/1ps

module test_core_sfr_bank_decoder;
	import csbd_pkg::*;
	localparam csbd_inst_e G = CSBD_INST_GENERAL;
	logic        sys_clk, rstn, dm_rd, dm_wr, pc_step, dm_rvalid, push_stb;
	logic        short_jump_instruction, short_call_instruction, long_jump_instruction;
	logic        long_call_instruction, alu_carry_we, alu_carry, alu_half_carry_we;
	logic        alu_half_carry, alu_zero_we, alu_zero, clear_watchdog_instruction;
	logic        sleep_instruction, watchdog_timeout, instruction_clock, timer0_mode_setting;
	logic        cfg_timer0_low_osc, timer0_external_clock_pin, low_osc_clk_in;
	logic        port_read_option, fpage_wr_stb, fpage_rd_stb, spage_wr_stb, spage_rd_stb;
	logic [4:0]  fs_addr;
	logic [6:0]  dm_addr;
	logic [7:0]  dm_wdata, dm_rdata, fs_wdata, fs_rdata, port_a_pin_in, port_a_dir_out;
	logic [7:0]  port_a_out;
	logic [10:0] inst_target, pc_out, push_addr;
	csbd_inst_e  inst_class;
	int          failures, n_compared;

	csbd_core dut_u (.sys_clk, .rstn, .inst_class, .dm_rd, .dm_wr, .dm_addr, .dm_wdata,
		.dm_rdata, .dm_rvalid, .fpage_wr_stb, .fpage_rd_stb, .spage_wr_stb, .spage_rd_stb,
		.fs_addr, .fs_wdata, .fs_rdata, .pc_step, .short_jump_instruction,
		.short_call_instruction, .long_jump_instruction, .long_call_instruction,
		.inst_target, .pc_out, .push_stb, .push_addr, .alu_carry_we, .alu_carry,
		.alu_half_carry_we, .alu_half_carry, .alu_zero_we, .alu_zero,
		.clear_watchdog_instruction, .sleep_instruction, .watchdog_timeout,
		.instruction_clock, .timer0_mode_setting, .cfg_timer0_low_osc,
		.timer0_external_clock_pin, .low_osc_clk_in, .port_a_pin_in, .port_a_dir_out,
		.port_read_option, .port_a_out);
	csbd_fs_model fs_u (.sys_clk, .fpage_wr_stb, .fpage_rd_stb, .spage_wr_stb,
		.spage_rd_stb, .fs_addr, .fs_wdata, .fs_rdata);

	// ==========================================================
	// shared tasks
	task end_sim;
		$display("tb: %0d compared, %0d failures", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task chk(input logic [10:0] s, input logic [10:0] e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task wr(input csbd_inst_e c, input logic [6:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		inst_class = c;
		dm_addr = a;
		dm_wdata = d;
		dm_wr = 1'h1;
		@(negedge sys_clk);
		dm_wr = 1'h0;
	endtask : wr
	task rc(input csbd_inst_e c, input logic [6:0] a, input logic [7:0] e);
		int i;
		@(negedge sys_clk);
		inst_class = c;
		dm_addr = a;
		dm_rd = 1'h1;
		@(negedge sys_clk);
		dm_rd = 1'h0;
		i = 0;
		do begin
			@(negedge sys_clk);
			i++;
		end while (dm_rvalid !== 1'h1 && i < 4);
		if (dm_rvalid !== 1'h1) begin
			failures++;
			$display("MISMATCH t=%0t read return missing", $time);
			end_sim();
		end else begin
			chk(dm_rdata, e);
		end
	endtask : rc
	task pcop(input logic [3:0] k, input logic [10:0] t);
		@(negedge sys_clk);
		{long_call_instruction, long_jump_instruction} = k[3:2];
		{short_call_instruction, short_jump_instruction} = k[1:0];
		inst_target = t;
		@(negedge sys_clk);
		{long_call_instruction, long_jump_instruction} = 2'h0;
		{short_call_instruction, short_jump_instruction} = 2'h0;
	endtask : pcop
	task sp(input logic [8:0] v);
		@(negedge sys_clk);
		{alu_carry_we, alu_carry, alu_half_carry_we, alu_half_carry, alu_zero_we, alu_zero,
			clear_watchdog_instruction, sleep_instruction, watchdog_timeout} = v;
		@(negedge sys_clk);
		{alu_carry_we, alu_half_carry_we, alu_zero_we} = 3'h0;
		{clear_watchdog_instruction, sleep_instruction, watchdog_timeout} = 3'h0;
	endtask : sp
	task tick(input logic osc);
		@(negedge sys_clk);
		if (osc) low_osc_clk_in = 1'h1;
		else timer0_external_clock_pin = 1'h1;
		repeat (3) @(negedge sys_clk);
		{low_osc_clk_in, timer0_external_clock_pin} = 2'h0;
		repeat (3) @(negedge sys_clk);
	endtask : tick

	// ==========================================================
	// scenarios
	task t_reset;
		rc(G, 7'h03, 8'h18);
		rc(G, 7'h02, 8'h00);
		rc(G, 7'h04, 8'h00);
		$display("tb: reset done");
	endtask : t_reset
	task t_bank;
		wr(G, 7'h25, 8'hA5);
		wr(G, 7'h50, 8'h3C);
		wr(G, 7'h03, 8'h58);
		wr(G, 7'h25, 8'h5A);
		wr(G, 7'h03, 8'hD8);
		rc(G, 7'h25, 8'h5A);
		rc(G, 7'h50, 8'h3C);
		wr(G, 7'h04, 8'h25);
		wr(G, 7'h03, 8'h98);
		rc(G, 7'h25, 8'hA5);
		rc(G, 7'h04, 8'h25);
		$display("tb: bank done");
	endtask : t_bank
	task t_indirect;
		wr(G, 7'h04, 8'hA5);
		rc(G, 7'h00, 8'hA5);
		rc(G, 7'h04, 8'hA5);
		wr(G, 7'h00, 8'h77);
		wr(G, 7'h03, 8'h18);
		rc(G, 7'h25, 8'h77);
		wr(G, 7'h03, 8'h58);
		rc(G, 7'h00, 8'h5A);
		$display("tb: indirect done");
	endtask : t_indirect
	task t_fs;
		wr(G, 7'h03, 8'hD8);
		wr(CSBD_INST_F_WRITE, 7'h05, 8'hC3);
		wr(CSBD_INST_S_WRITE, 7'h05, 8'h3C);
		chk(fs_addr, 11'h005);
		rc(CSBD_INST_F_READ, 7'h05, 8'hC3);
		rc(CSBD_INST_S_READ, 7'h05, 8'h3C);
		wr(CSBD_INST_F_WRITE, 7'h25, 8'h11);
		wr(G, 7'h03, 8'h18);
		rc(G, 7'h25, 8'h77);
		$display("tb: page access done");
	endtask : t_fs
	task t_pc;
		pcop(4'h4, 11'h6F3);
		chk(pc_out, 11'h6F3);
		@(negedge sys_clk);
		pc_step = 1'h1;
		@(negedge sys_clk);
		pc_step = 1'h0;
		chk(pc_out, 11'h6F4);
		wr(G, 7'h0A, 8'h05);
		rc(G, 7'h0A, 8'h00);
		pcop(4'h2, 11'h034);
		chk(pc_out, 11'h534);
		chk(push_addr, 11'h6F5);
		pcop(4'h1, 11'h1C3);
		chk(pc_out, 11'h5C3);
		wr(G, 7'h02, 8'h12);
		chk(pc_out, 11'h512);
		rc(G, 7'h02, 8'h12);
		pcop(4'h8, 11'h7FF);
		chk(pc_out, 11'h7FF);
		chk(push_addr, 11'h513);
		$display("tb: counter done");
	endtask : t_pc
	task t_status;
		sp(9'b110000000);
		rc(G, 7'h03, 8'h19);
		sp(9'b101100000);
		rc(G, 7'h03, 8'h1A);
		sp(9'b000011000);
		rc(G, 7'h03, 8'h1E);
		sp(9'b000010010);
		rc(G, 7'h03, 8'h12);
		sp(9'b000000001);
		rc(G, 7'h03, 8'h02);
		sp(9'b000000100);
		rc(G, 7'h03, 8'h1A);
		$display("tb: status done");
	endtask : t_status
	task t_timer;
		wr(G, 7'h01, 8'hF0);
		rc(G, 7'h01, 8'hF0);
		@(negedge sys_clk);
		instruction_clock = 1'h1;
		repeat (3) @(negedge sys_clk);
		instruction_clock = 1'h0;
		rc(G, 7'h01, 8'hF3);
		timer0_mode_setting = 1'h1;
		tick(1'h0);
		tick(1'h0);
		rc(G, 7'h01, 8'hF5);
		cfg_timer0_low_osc = 1'h1;
		tick(1'h1);
		rc(G, 7'h01, 8'hF6);
		timer0_mode_setting = 1'h0;
		$display("tb: timer done");
	endtask : t_timer
	task t_port;
		wr(G, 7'h05, 8'h3C);
		chk(port_a_out, 11'h03C);
		port_a_pin_in = 8'hA5;
		port_a_dir_out = 8'hF0;
		port_read_option = 1'h1;
		repeat (3) @(negedge sys_clk);
		rc(G, 7'h05, 8'h35);
		port_read_option = 1'h0;
		rc(G, 7'h05, 8'hA5);
		$display("tb: port done");
	endtask : t_port

	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		{failures, n_compared} = '0;
		{rstn, dm_rd, dm_wr, pc_step, dm_addr, dm_wdata, inst_target} = '0;
		{short_jump_instruction, short_call_instruction, long_jump_instruction} = '0;
		{long_call_instruction, alu_carry_we, alu_carry, alu_half_carry_we} = '0;
		{alu_half_carry, alu_zero_we, alu_zero, clear_watchdog_instruction} = '0;
		{sleep_instruction, watchdog_timeout, instruction_clock, timer0_mode_setting} = '0;
		{cfg_timer0_low_osc, timer0_external_clock_pin, low_osc_clk_in} = '0;
		{port_read_option, port_a_pin_in, port_a_dir_out} = '0;
		inst_class = G;
		repeat (20) @(negedge sys_clk);
		rstn = 1'h1;
		t_reset();
		t_bank();
		t_indirect();
		t_fs();
		t_pc();
		t_status();
		t_timer();
		t_port();
		end_sim();
	end
endmodule : test_core_sfr_bank_decoder
